// *** logic/succ_seq.sv ***
// successor sequencer: picks the next motion block at end or on interrupt
// assumes a motion core that reports block start, set-position end and finiteness
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module succ_seq
	import succ_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// trigger pins
	input wire logic [NDIN-1:0] din_pins,
	// motion core status
	input wire logic block_start,
	input wire logic block_at_end,
	input wire logic block_finite,
	input wire logic axis_referenced_flag,
	input wire logic [NCAM*8-1:0] cam_result_array,
	// motion core commands
	output succ_cmd_s next_cmd,
	output logic [BLKW-1:0] preload_block,
	output logic preload_valid
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} seq_state_e;

	// first active slot, A first
	function automatic logic [2:0] first_hit(input logic [NSLOT-1:0] v);
		first_hit = 3'h7;
		for (int i = NSLOT - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_hit = 3'(i);
			end
		end
	endfunction

	seq_state_e state_q, state_d;
	logic command_mode_select_q;
	logic [BLKW-1:0] buffered_successor_q;
	logic [31:0] loop_trigger_delay_q;
	logic [31:0] user_param_q;
	logic [BLKW-1:0] end_successor_q [NSLOT];
	logic [BLKW-1:0] interrupt_successor_q [NSLOT];
	logic [16:0] trigger_source_array_q [NSLOT];
	logic [NDIN-1:0] din_meta_q, din_q;
	logic [31:0] loop_cnt_q;
	logic loop_out_q;
	logic pend_q;
	logic [BLKW-1:0] pend_blk_q;
	succ_cmd_s cmd_q, cmd_d;
	logic [BLKW-1:0] last_q;
	logic [NSLOT-1:0] trig;
	logic [NSLOT-1:0] end_hit, int_hit;
	logic [2:0] end_idx, int_idx;
	logic [BLKW-1:0] end_blk, int_blk;
	logic running, buf_ok;
	logic [7:0] aw_q, ar_q;
	logic aw_full_q, w_full_q;
	logic [31:0] w_q;
	logic do_wr;
	logic wr_ok, rd_ok;
	logic [31:0] rd_word;

	// two-stage synchroniser on the trigger pins
	always_ff @(posedge aclk) begin
		din_meta_q <= din_pins;
		din_q <= din_meta_q;
	end

	// one evaluator per slot; element n feeds trigger n
	for (genvar g = 0; g < NSLOT; g++) begin : g_trig
		trig_eval u_eval (
			.cfg(trig_cfg_s'(trigger_source_array_q[g])),
			.din(din_q),
			.axis_referenced_flag(axis_referenced_flag),
			.loop_trigger_output({31'h0, loop_out_q}),
			.cam_result_array(cam_result_array),
			.user_param(user_param_q),
			.active(trig[g])
		);
		assign end_hit[g] = trig[g] && (end_successor_q[g] != BLK_INACTIVE);
		assign int_hit[g] = trig[g] && (interrupt_successor_q[g] != BLK_INACTIVE);
	end

	// priority selection, A wins
	assign end_idx = first_hit(end_hit);
	assign int_idx = first_hit(int_hit);
	assign end_blk = (end_idx < 3'(NSLOT)) ? end_successor_q[end_idx] : BLK_INACTIVE;
	assign int_blk = (int_idx < 3'(NSLOT)) ? interrupt_successor_q[int_idx] : BLK_INACTIVE;
	assign running = (state_q == ST_RUN);
	assign buf_ok = (buffered_successor_q != BLK_INACTIVE);

	// successor decision; end checks happen only on the end pulse
	always_comb begin
		state_d = state_q;
		cmd_d = '0;
		cmd_d.block = cmd_q.block;
		unique case (state_q)
			ST_IDLE: begin
				if (block_start) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (block_at_end) begin
					state_d = ST_IDLE;
					if (pend_q && block_finite) begin
						cmd_d = '{start: 1'b1, abort: 1'b0, block: pend_blk_q};
					end else if (|end_hit) begin
						cmd_d = '{start: 1'b1, abort: 1'b0, block: end_blk};
					end else if (buf_ok) begin
						cmd_d = '{start: 1'b1, abort: 1'b0, block: buffered_successor_q};
					end
				end else if (|int_hit && !command_mode_select_q) begin
					cmd_d = '{start: 1'b1, abort: 1'b1, block: int_blk};
				end
				if (cmd_d.start) begin
					state_d = ST_RUN;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// sequencer state and command register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			cmd_q <= '{start: 1'b0, abort: 1'b0, block: BLK_INACTIVE};
			last_q <= BLK_INACTIVE;
		end else begin
			state_q <= state_d;
			cmd_q <= cmd_d;
			if (cmd_d.start) begin
				last_q <= cmd_d.block;
			end
		end
	end

	// mode 1 interrupt hit is held until the block ends
	always_ff @(posedge aclk) begin
		if (!aresetn || !running || block_at_end) begin
			pend_q <= 1'b0;
			pend_blk_q <= BLK_INACTIVE;
		end else if (|int_hit && command_mode_select_q && !pend_q) begin
			pend_q <= 1'b1;
			pend_blk_q <= int_blk;
		end
	end

	// block duration timer; restarts on every new block
	always_ff @(posedge aclk) begin
		if (!aresetn || !running || block_start || cmd_q.start) begin
			loop_cnt_q <= 32'h00000000;
			loop_out_q <= 1'b0;
		end else if (loop_cnt_q >= loop_trigger_delay_q) begin
			loop_out_q <= 1'b1;
		end else begin
			loop_cnt_q <= loop_cnt_q + 32'h00000001;
		end
	end

	// outputs; held mode 1 interrupt target, else buffered target, offered while the block runs
	assign next_cmd = cmd_q;
	assign preload_valid = running && (pend_q || buf_ok);
	assign preload_block = pend_q ? pend_blk_q : buffered_successor_q;

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
	assign s_axi_wready = !w_full_q && !s_axi_bvalid;
	assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wr_ok = (aw_q[1:0] == 2'h0) && (aw_q <= OFS_USER_PARAM || (aw_q >= OFS_END_SUCC &&
		aw_q < OFS_TRIG_SRC + 8'(4 * NSLOT) && aw_q[4:0] < 5'(4 * NSLOT))) && aw_q != OFS_STATUS;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				w_q <= s_axi_wdata;
			end
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// configuration registers; strobes ignored, whole words written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			command_mode_select_q <= 1'b0;
			buffered_successor_q <= BLK_INACTIVE;
			loop_trigger_delay_q <= LOOP_DELAY_RST;
			user_param_q <= 32'h00000000;
			for (int i = 0; i < NSLOT; i++) begin
				end_successor_q[i] <= BLK_INACTIVE;
				interrupt_successor_q[i] <= BLK_INACTIVE;
				trigger_source_array_q[i] <= TRIG_RST;
			end
		end else if (do_wr && wr_ok) begin
			unique case (aw_q[7:5])
				3'h0: begin
					if (aw_q == OFS_CTRL) command_mode_select_q <= w_q[0];
					if (aw_q == OFS_BUFFERED) buffered_successor_q <= w_q[BLKW-1:0];
					if (aw_q == OFS_LOOP_DELAY) loop_trigger_delay_q <= w_q;
					if (aw_q == OFS_USER_PARAM) user_param_q <= w_q;
				end
				3'h1: end_successor_q[aw_q[4:2]] <= w_q[BLKW-1:0];
				3'h2: interrupt_successor_q[aw_q[4:2]] <= w_q[BLKW-1:0];
				default: trigger_source_array_q[aw_q[4:2]] <= w_q[16:0];
			endcase
		end
	end

	// read decode
	assign rd_ok = (ar_q[1:0] == 2'h0) && (ar_q <= OFS_USER_PARAM || (ar_q >= OFS_END_SUCC &&
		ar_q < OFS_TRIG_SRC + 8'(4 * NSLOT) && ar_q[4:0] < 5'(4 * NSLOT)));
	always_comb begin
		rd_word = 32'h00000000;
		unique case (ar_q[7:5])
			3'h0: begin
				if (ar_q == OFS_CTRL) rd_word = {31'h0, command_mode_select_q};
				if (ar_q == OFS_STATUS) begin
					rd_word[ST_RUN_BIT] = running;
					rd_word[ST_PEND_BIT] = pend_q;
					rd_word[ST_LOOP_BIT] = loop_out_q;
					rd_word[ST_TRIG_LSB +: NSLOT] = trig;
					rd_word[ST_LAST_LSB +: BLKW] = last_q;
				end
				if (ar_q == OFS_BUFFERED) rd_word = {24'h000000, buffered_successor_q};
				if (ar_q == OFS_LOOP_DELAY) rd_word = loop_trigger_delay_q;
				if (ar_q == OFS_USER_PARAM) rd_word = user_param_q;
			end
			3'h1: rd_word = {24'h000000, end_successor_q[ar_q[4:2]]};
			3'h2: rd_word = {24'h000000, interrupt_successor_q[ar_q[4:2]]};
			3'h3: rd_word = {15'h0, trigger_source_array_q[ar_q[4:2]]};
			default: rd_word = 32'h00000000;
		endcase
		if (!rd_ok) rd_word = 32'h00000000;
	end

	// read channel: address held one cycle, data answered the next
	logic ar_full_q;
	assign s_axi_arready = !ar_full_q && !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_full_q <= 1'b0;
			ar_q <= 8'h00;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			ar_full_q <= 1'b1;
			ar_q <= s_axi_araddr;
		end else if (ar_full_q) begin
			ar_full_q <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// checks
	property p_end_only;
		@(posedge aclk) disable iff (!aresetn) next_cmd.start && !next_cmd.abort |-> $past(block_at_end);
	endproperty
	a_end_only: assert property (p_end_only) else $error("non-abort start away from block end");
	property p_abort_mode;
		@(posedge aclk) disable iff (!aresetn) next_cmd.abort |-> $past(!command_mode_select_q && running);
	endproperty
	a_abort_mode: assert property (p_abort_mode) else $error("abort without mode 0");
	property p_int_now;
		@(posedge aclk) disable iff (!aresetn)
		running && !block_at_end && (|int_hit) && !command_mode_select_q |=> next_cmd.start && next_cmd.abort;
	endproperty
	a_int_now: assert property (p_int_now) else $error("interrupt successor not started at once");
	property p_preload_only;
		@(posedge aclk) disable iff (!aresetn)
		running && !block_at_end && (|int_hit) && command_mode_select_q |=> !next_cmd.start && pend_q;
	endproperty
	a_preload_only: assert property (p_preload_only) else $error("mode 1 trigger did not only preload");
	property p_prio;
		@(posedge aclk) disable iff (!aresetn)
		running && block_at_end && !pend_q && (|end_hit) |=> next_cmd.start && next_cmd.block == $past(end_blk);
	endproperty
	a_prio: assert property (p_prio) else $error("wrong end successor chosen");
	property p_buffered;
		@(posedge aclk) disable iff (!aresetn) running && block_at_end && !pend_q && !(|end_hit) && buf_ok
		|=> next_cmd.start && next_cmd.block == $past(buffered_successor_q);
	endproperty
	a_buffered: assert property (p_buffered) else $error("buffered successor not continued");
	property p_endless;
		@(posedge aclk) disable iff (!aresetn) running && block_at_end && pend_q && !block_finite && !(|end_hit)
		&& !buf_ok |=> !next_cmd.start;
	endproperty
	a_endless: assert property (p_endless) else $error("preloaded successor ran after endless block");
	property p_loop;
		@(posedge aclk) disable iff (!aresetn) running && !cmd_q.start && !block_start && !block_at_end
		&& loop_cnt_q >= loop_trigger_delay_q |=> loop_out_q || !running;
	endproperty
	a_loop: assert property (p_loop) else $error("loop trigger not raised after duration");
endmodule // succ_seq

// *** logic/succ_pkg.sv ***
// successor sequencer package: register map, field layout, carriers
// assumes a 32-bit AXI4-Lite register bus and one drive control clock
package succ_pkg;
	localparam int NSLOT = 5;
	localparam int NDIN = 8;
	localparam int NCAM = 8;
	localparam int BLKW = 8;
	// byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_BUFFERED = 8'h08;
	localparam logic [7:0] OFS_LOOP_DELAY = 8'h0c;
	localparam logic [7:0] OFS_USER_PARAM = 8'h10;
	localparam logic [7:0] OFS_END_SUCC = 8'h20;
	localparam logic [7:0] OFS_INT_SUCC = 8'h40;
	localparam logic [7:0] OFS_TRIG_SRC = 8'h60;
	// reset values; all-ones block number means inactive
	localparam logic [BLKW-1:0] BLK_INACTIVE = 8'hff;
	localparam logic [31:0] LOOP_DELAY_RST = 32'h0000_03e8;
	localparam logic [16:0] TRIG_RST = 17'h00000;
	// status field positions
	localparam int ST_RUN_BIT = 0;
	localparam int ST_PEND_BIT = 1;
	localparam int ST_LOOP_BIT = 2;
	localparam int ST_TRIG_LSB = 8;
	localparam int ST_LAST_LSB = 16;
	// trigger source kinds
	typedef enum logic [1:0] {
		TRIG_INPUT = 2'h0,
		TRIG_HIGH = 2'h1,
		TRIG_PARAM = 2'h2,
		TRIG_INPUT_INV = 2'h3
	} trig_kind_e;
	// indirect condition forms
	typedef enum logic [1:0] {
		FORM_BOOL = 2'h0,
		FORM_BIT = 2'h1,
		FORM_ELEM = 2'h2,
		FORM_ELEM_BIT = 2'h3
	} cond_form_e;
	// indirect parameter selectors, own axis only
	typedef enum logic [1:0] {
		PAR_REFERENCED = 2'h0,
		PAR_LOOP_OUT = 2'h1,
		PAR_CAM = 2'h2,
		PAR_USER = 2'h3
	} cond_param_e;
	// one trigger_source_array / indirect_condition_array element, bits 16:0
	typedef struct packed {
		logic [4:0] bitsel;
		logic [2:0] elem;
		cond_param_e param;
		cond_form_e form;
		logic [2:0] din_sel;
		trig_kind_e kind;
	} trig_cfg_s;
	// successor command towards the motion core
	typedef struct packed {
		logic start;
		logic abort;
		logic [BLKW-1:0] block;
	} succ_cmd_s;
endpackage

// *** logic/trig_eval.sv ***
// one successor trigger: direct, inverted, constant or indirect condition
// assumes synchronised inputs and same-clock parameter values
`timescale 1ns/100ps
module trig_eval
	import succ_pkg::*;
(
	// configuration of this trigger
	input wire trig_cfg_s cfg,
	// sources, all from this axis
	input wire logic [NDIN-1:0] din,
	input wire logic axis_referenced_flag,
	input wire logic [31:0] loop_trigger_output,
	input wire logic [NCAM*8-1:0] cam_result_array,
	input wire logic [31:0] user_param,
	// condition level
	output logic active
);
	logic [31:0] word;
	logic [31:0] elem_word;
	logic cond;

	// element select; scalars use the whole value whatever element is set
	assign elem_word = (cfg.param == PAR_CAM) ? {24'h000000, cam_result_array[cfg.elem*8 +: 8]} : word;
	// only this axis's own parameters are reachable
	assign word = (cfg.param == PAR_REFERENCED) ? {31'h0, axis_referenced_flag} :
		(cfg.param == PAR_LOOP_OUT) ? loop_trigger_output :
		(cfg.param == PAR_CAM) ? cam_result_array[31:0] : user_param;

	// four notations of the indirect condition
	always_comb begin
		unique case (cfg.form)
			FORM_BOOL: cond = (word != 32'h00000000);
			FORM_BIT: cond = word[cfg.bitsel];
			FORM_ELEM: cond = (elem_word != 32'h00000000);
			FORM_ELEM_BIT: cond = elem_word[cfg.bitsel];
		endcase
	end

	// source kind selection
	always_comb begin
		unique case (cfg.kind)
			TRIG_INPUT: active = din[cfg.din_sel];
			TRIG_HIGH: active = 1'b1;
			TRIG_PARAM: active = cond;
			TRIG_INPUT_INV: active = ~din[cfg.din_sel];
		endcase
	end
endmodule // trig_eval

// *** sim/succ_partner.sv ***
// motion core and trigger source stand-in for the successor sequencer
// assumes the bench calls its tasks from the clock domain of aclk
`timescale 1ns/100ps
module succ_partner
	import succ_pkg::*;
(
	// clock
	input wire logic aclk,
	// trigger pins and own-axis parameters
	output logic [NDIN-1:0] din_pins,
	output logic axis_referenced_flag,
	output logic [NCAM*8-1:0] cam_result_array,
	// motion core status
	output logic block_start,
	output logic block_at_end,
	output logic block_finite
);
	// quiet, finite motion at time zero
	initial begin
		din_pins = '0;
		axis_referenced_flag = 1'b0;
		cam_result_array = '0;
		block_start = 1'b0;
		block_at_end = 1'b0;
		block_finite = 1'b1;
	end
	// sources change only on an edge; bench settles them before any end pulse
	task automatic src(input logic [NDIN-1:0] p, input logic r, input logic [63:0] cm, input logic f);
		@(posedge aclk);
		din_pins <= p;
		axis_referenced_flag <= r;
		cam_result_array <= cm;
		block_finite <= f;
	endtask
	// one-cycle pulse, so a block never looks started twice
	task automatic pulse(input logic at_end);
		@(posedge aclk);
		if (at_end) block_at_end <= 1'b1; else block_start <= 1'b1;
		@(posedge aclk);
		block_at_end <= 1'b0;
		block_start <= 1'b0;
	endtask
endmodule // succ_partner

// *** sim/tb_succ_seq.sv ***
// self-checking bench for the successor sequencer
// assumes the register map and field layout of succ_pkg
`timescale 1ns/100ps
module tb_succ_seq
	import succ_pkg::*;
;
	logic aclk;
	logic aresetn;
	logic [7:0] awaddr, araddr, sb;
	logic [31:0] wdata, rv;
	logic awvalid, wvalid, bready, arvalid, rready, sa;
	logic [1:0] resp;
	wire logic awready, wready, bvalid, arready, rvalid, bs, be, bf, rf, pv;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [NDIN-1:0] din;
	wire logic [NCAM*8-1:0] cam;
	wire logic [7:0] pblk;
	succ_cmd_s cmd;
	int mismatches = 0;
	int check_count = 0;
	always #50 aclk = ~aclk;
	succ_seq u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .din_pins(din), .block_start(bs),
		.block_at_end(be), .block_finite(bf), .axis_referenced_flag(rf), .cam_result_array(cam),
		.next_cmd(cmd), .preload_block(pblk), .preload_valid(pv));
	succ_partner u_part (.aclk(aclk), .din_pins(din), .axis_referenced_flag(rf), .cam_result_array(cam),
		.block_start(bs), .block_at_end(be), .block_finite(bf));
	// verdict and end of run, also reached from the wr and rd timeouts
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// axi write: readies and response sampled at the rising edge that takes them
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ah = 1'b1;
		wh = 1'b1;
		bh = 1'b1;
		for (int n = 0; n < 40 && bh; n++) begin
			@(posedge aclk);
			if (ah && awready) begin awvalid <= 1'b0; ah = 1'b0; end
			if (wh && wready) begin wvalid <= 1'b0; wh = 1'b0; end
			if (bvalid) begin resp = bresp; bready <= 1'b0; bh = 1'b0; end
		end
		if (bh) begin mismatches++; final_report; end
	endtask
	task automatic rd(input logic [7:0] a);
		logic ah, rh;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		ah = 1'b1;
		rh = 1'b1;
		for (int n = 0; n < 40 && rh; n++) begin
			@(posedge aclk);
			if (ah && arready) begin arvalid <= 1'b0; ah = 1'b0; end
			if (rvalid) begin rv = rdata; resp = rresp; rready <= 1'b0; rh = 1'b0; end
		end
		if (rh) begin mismatches++; final_report; end
	endtask
	// absence of a start is legal, so this wait is bounded but not fatal
	task automatic exp_start(input logic e, input logic [7:0] b, input logic ab);
		logic g;
		g = 1'b0;
		for (int n = 0; n < 8 && !g; n++) begin
			@(negedge aclk);
			if (cmd.start === 1'b1) begin g = 1'b1; sb = cmd.block; sa = cmd.abort; end
		end
		chk("start", e, g);
		if (e && g) begin chk("block", b, sb); chk("abort", ab, sa); end
	endtask
	// one end-of-block decision with trigger 0 configured as c
	task automatic endq(input trig_cfg_s c, input logic [7:0] p, input logic r, input logic [63:0] cm,
		input logic [31:0] u, input int w, input logic e);
		wr(OFS_TRIG_SRC, 32'(c));
		wr(OFS_USER_PARAM, u);
		u_part.src(p, r, cm, 1'b1);
		u_part.pulse(1'b0);
		repeat (w + 4) @(posedge aclk);
		u_part.pulse(1'b1);
		exp_start(e, 8'h21, 1'b0);
	endtask
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h00000000;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values and refused accesses
		rd(OFS_END_SUCC);
		chk("end_a", 32'h0000_00ff, rv);
		rd(OFS_LOOP_DELAY);
		chk("loop_delay", LOOP_DELAY_RST, rv);
		rd(OFS_TRIG_SRC);
		chk("trig_src", 32'h0, rv);
		rd(8'h80);
		chk("rresp", 32'h2, resp);
		chk("rdata", 32'h0, rv);
		wr(OFS_STATUS, 32'hffff_ffff);
		chk("bresp", 32'h2, resp);
		// end slots with a plain input each; same outcome in both command modes
		for (int n = 0; n < 5; n++) begin
			wr(OFS_END_SUCC + 8'(4 * n), 32'h10 + n);
			wr(OFS_TRIG_SRC + 8'(4 * n), 32'(trig_cfg_s'{5'h0, 3'h0, PAR_REFERENCED, FORM_BOOL, 3'(n), TRIG_INPUT}));
		end
		for (int m = 0; m < 2; m++) begin
			wr(OFS_CTRL, 32'(m));
			u_part.pulse(1'b0);
			for (int k = 0; k < 5; k++) begin
				u_part.src(8'((8'h1f >> k) << k), 1'b0, '0, 1'b1);
				exp_start(1'b0, 8'h0, 1'b0);
				u_part.pulse(1'b1);
				exp_start(1'b1, 8'(8'h10 + k), 1'b0);
			end
			u_part.src(8'h0, 1'b0, '0, 1'b1);
			u_part.pulse(1'b1);
		end
		for (int n = 1; n < 5; n++) wr(OFS_END_SUCC + 8'(4 * n), 32'hff);
		wr(OFS_END_SUCC, 32'h21);
		wr(OFS_LOOP_DELAY, 32'd20);
		// inverted input, constant high and every indirect form on slot A; all but constant high false then true
		endq('{5'h0, 3'h0, PAR_REFERENCED, FORM_BOOL, 3'h1, TRIG_INPUT_INV}, 8'h02, 0, '0, 0, 0, 0);
		endq('{5'h0, 3'h0, PAR_REFERENCED, FORM_BOOL, 3'h1, TRIG_INPUT_INV}, 8'h0, 0, '0, 0, 0, 1);
		endq('{5'h0, 3'h0, PAR_REFERENCED, FORM_BOOL, 3'h0, TRIG_HIGH}, 8'h0, 0, '0, 0, 0, 1);
		endq('{5'h0, 3'h0, PAR_REFERENCED, FORM_BOOL, 3'h0, TRIG_PARAM}, 8'hff, 0, '1, '1, 0, 0);
		endq('{5'h0, 3'h0, PAR_REFERENCED, FORM_BOOL, 3'h0, TRIG_PARAM}, 8'h0, 1, '0, 0, 0, 1);
		endq('{5'h5, 3'h0, PAR_USER, FORM_BIT, 3'h0, TRIG_PARAM}, 8'h0, 1, '1, 32'hffff_ffdf, 0, 0);
		endq('{5'h5, 3'h0, PAR_USER, FORM_BIT, 3'h0, TRIG_PARAM}, 8'h0, 0, '0, 32'h20, 0, 1);
		endq('{5'h0, 3'h4, PAR_CAM, FORM_ELEM, 3'h0, TRIG_PARAM}, 8'h0, 1, 64'hffff_ff00_ffff_ffff, 0, 0, 0);
		endq('{5'h0, 3'h4, PAR_CAM, FORM_ELEM, 3'h0, TRIG_PARAM}, 8'h0, 0, 64'h0000_0001_0000_0000, 0, 0, 1);
		endq('{5'h6, 3'h2, PAR_CAM, FORM_ELEM_BIT, 3'h0, TRIG_PARAM}, 8'h0, 1, 64'hffff_ffff_ffbf_ffff, 0, 0, 0);
		endq('{5'h6, 3'h2, PAR_CAM, FORM_ELEM_BIT, 3'h0, TRIG_PARAM}, 8'h0, 0, 64'h0000_0000_0040_0000, 0, 0, 1);
		endq('{5'h0, 3'h0, PAR_LOOP_OUT, FORM_BIT, 3'h0, TRIG_PARAM}, 8'h0, 0, '0, 0, 0, 0);
		endq('{5'h0, 3'h0, PAR_LOOP_OUT, FORM_BIT, 3'h0, TRIG_PARAM}, 8'h0, 0, '0, 0, 30, 1);
		// interrupting successor B: abort at once in mode 0
		wr(OFS_END_SUCC, 32'hff);
		wr(OFS_INT_SUCC + 8'h04, 32'h32);
		wr(OFS_CTRL, 32'h0);
		u_part.src(8'h0, 1'b0, '0, 1'b1);
		u_part.pulse(1'b0);
		u_part.src(8'h02, 1'b0, '0, 1'b1);
		exp_start(1'b1, 8'h32, 1'b1);
		// mode 1: preload only, start at end of a finite block alone
		wr(OFS_CTRL, 32'h1);
		for (int f = 1; f >= 0; f--) begin
			u_part.src(8'h0, 1'b0, '0, 1'(f));
			u_part.pulse(1'b0);
			u_part.src(8'h02, 1'b0, '0, 1'(f));
			exp_start(1'b0, 8'h0, 1'b0);
			chk("preload_valid", 32'h1, pv);
			chk("preload_block", 32'h32, pblk);
			u_part.pulse(1'b1);
			exp_start(1'(f), 8'h32, 1'b0);
		end
		// buffered successor, end slots all inactive, target in mode 1
		u_part.src(8'h0, 1'b0, '0, 1'b1);
		wr(OFS_BUFFERED, 32'h40);
		rd(OFS_BUFFERED);
		chk("buffered", 32'h40, rv);
		u_part.pulse(1'b0);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk("preload_valid", 32'h1, pv);
		chk("preload_block", 32'h40, pblk);
		u_part.pulse(1'b1);
		exp_start(1'b1, 8'h40, 1'b0);
		rd(OFS_STATUS);
		chk("status", 32'h0040_0001, rv);
		final_report;
	end
endmodule // tb_succ_seq
